// *** fesm_core.sv ***
// Overview of operation
// - Suspend code during erase suspends it
// - Suspend honoured only during erase cycle
// - Suspend in time-out window ends window
// - Toggle stops 0.1 to 15 us
// - Erased sector reads invalid while suspended
// - Suspended: only resume and reset accepted
// - Reset while suspended abandons erase
// - Resume code continues suspended erase
// - Locked sector program or erase ignored
// - Lock bits read only from bus
// - Lock register bit layouts, secured bit
// - Error reset returns read within 25us
// - Reset ignored during program or bulk
// - Reset aborts sector erase within 25us
// - System reset aborts cycle to read
// - Static memory only with select high
// - Boot over main; sram/regs over flash
// - Space map bits and writable boot value
// - Timer flag 0 counting, 1 erasing
// - Toggle inverts per read while busy
module fesm_core (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // Core bus strobes (active high, one cycle per access)
  input  wire logic        bus_wr_in,
  input  wire logic        bus_rd_in,
  input  wire logic        bus_fetch_in,
  input  wire logic [11:0] bus_addr_in,
  input  wire logic [7:0]  bus_wdata_in,
  // Decoded selects from address_decode_array
  input  wire logic [7:0]  main_sector_selects_in,
  input  wire logic [3:0]  boot_sector_selects_in,
  input  wire logic        static_memory_select_in,
  input  wire logic        control_register_space_in,
  input  wire logic        peripheral_space_in,
  // Non-volatile configuration
  input  wire logic [7:0]  main_lock_in,
  input  wire logic [7:0]  boot_lock_in,
  input  wire logic        secured_in,
  input  wire logic [7:0]  space_map_boot_in,
  // Erase engine side
  input  wire logic        erase_start_in,
  input  wire logic        busy_other_in,
  input  wire logic        error_in,
  // Read data and memory enables
  output logic [7:0]       bus_rdata_out,
  output logic             main_flash_en_out,
  output logic             boot_flash_en_out,
  output logic             sram_en_out,
  output logic             regs_en_out,
  output logic             periph_en_out,
  output logic             peripheral_io_enable_out,
  output logic             read_invalid_out,
  output logic             erase_active_out,
  output logic             erase_suspended_out,
  output logic             program_refused_out
);

  // ---------------------------------------------------------------------------
  // State and registers
  // ---------------------------------------------------------------------------
  fesm_pkg::fesm_state_e state_q;
  logic [7:0]  space_map_q;
  logic        map_loaded_q;
  logic [11:0] erase_sectors_q;
  logic [1:0]  unlock_q;
  logic        toggle_q;
  logic        in_reset_q;
  logic [7:0]  rdata_q;

  logic        any_sel;
  logic [11:0] sel_vec;
  logic        flash_wr;
  logic        is_suspend;
  logic        is_resume;
  logic        is_reset;
  logic        hits_erase;
  logic        susp_done;
  logic        rec_done;
  logic        rec_busy;
  logic        reg_rd;
  logic        reg_wr;
  logic [7:0]  reg_rdata;
  logic [7:0]  status;

  // ---------------------------------------------------------------------------
  // Decode priority
  // ---------------------------------------------------------------------------
  // Higher level selects mask lower ones
  always_comb begin
    logic high_lvl;
    logic boot_any;
    high_lvl          = static_memory_select_in || control_register_space_in ||
                        (peripheral_space_in && space_map_q[fesm_pkg::MAP_PIO_BIT]);
    boot_any          = |boot_sector_selects_in;
    sram_en_out       = static_memory_select_in &&
                        (bus_rd_in || bus_wr_in ||
                         (bus_fetch_in && space_map_q[fesm_pkg::MAP_PF_SRAM_BIT]));
    regs_en_out       = control_register_space_in && !static_memory_select_in;
    periph_en_out     = peripheral_space_in && space_map_q[fesm_pkg::MAP_PIO_BIT] &&
                        !static_memory_select_in && !control_register_space_in;
    boot_flash_en_out = boot_any && !high_lvl &&
                        ((bus_rd_in && space_map_q[fesm_pkg::MAP_RD_BOOT_BIT]) ||
                         (bus_fetch_in && space_map_q[fesm_pkg::MAP_PF_BOOT_BIT]) ||
                         bus_wr_in);
    main_flash_en_out = (|main_sector_selects_in) && !boot_any && !high_lvl &&
                        ((bus_rd_in && space_map_q[fesm_pkg::MAP_RD_MAIN_BIT]) ||
                         (bus_fetch_in && space_map_q[fesm_pkg::MAP_PF_MAIN_BIT]) ||
                         bus_wr_in);
  end

  assign sel_vec  = {boot_sector_selects_in, main_sector_selects_in};
  assign any_sel  = |sel_vec;
  assign flash_wr = bus_wr_in && any_sel && !regs_en_out && !sram_en_out;
  assign is_suspend = flash_wr && (bus_wdata_in == fesm_pkg::CMD_SUSPEND);
  assign is_resume  = flash_wr && (bus_wdata_in == fesm_pkg::CMD_RESUME);
  assign is_reset   = flash_wr && (bus_wdata_in == fesm_pkg::CMD_RESET_FLASH);
  assign hits_erase = |(sel_vec & erase_sectors_q);
  assign reg_rd     = bus_rd_in && regs_en_out;
  assign reg_wr     = bus_wr_in && regs_en_out;

  // ---------------------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------------------
  // Suspend takes effect after a fixed delay inside the allowed window
  fesm_counter #(.W(16)) u_susp_timer (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .load_in   (is_suspend && (state_q == fesm_pkg::FESM_ERASING ||
                               state_q == fesm_pkg::FESM_TIMEOUT)),
    .value_in  (16'(fesm_pkg::SUSP_DELAY_CYC)),
    .stop_in   (1'b0),
    .busy_out  (),
    .done_out  (susp_done)
  );

  // Recovery to read mode after abort; short, well under the bound
  fesm_counter #(.W(16)) u_rec_timer (
    .clk_in    (clk_in),
    .resetn_in (1'b1),
    .load_in   (!resetn_in || (is_reset && state_q != fesm_pkg::FESM_READ)),
    .value_in  (16'(fesm_pkg::ABORT_DELAY_CYC)),
    .stop_in   (1'b0),
    .busy_out  (rec_busy),
    .done_out  (rec_done)
  );

  // ---------------------------------------------------------------------------
  // Erase state machine
  // ---------------------------------------------------------------------------
  // A reset-flash during a program or bulk erase is not acted on
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_q <= fesm_pkg::FESM_READ;
    end else begin
      case (state_q)
        fesm_pkg::FESM_READ: begin
          if (erase_start_in && !busy_other_in && (|(sel_vec & ~{boot_lock_in[3:0], main_lock_in})))
            state_q <= fesm_pkg::FESM_TIMEOUT;
        end
        fesm_pkg::FESM_TIMEOUT: begin
          if (is_suspend)
            state_q <= fesm_pkg::FESM_SUSPWAIT;
          else if (is_reset && !busy_other_in)
            state_q <= fesm_pkg::FESM_READ;
          else if (rec_busy == 1'b0 && !erase_start_in && in_reset_q == 1'b0)
            state_q <= fesm_pkg::FESM_ERASING;
        end
        fesm_pkg::FESM_ERASING: begin
          if (is_suspend)
            state_q <= fesm_pkg::FESM_SUSPWAIT;
          else if (is_reset && !busy_other_in)
            state_q <= fesm_pkg::FESM_READ;
          else if (!erase_start_in && error_in)
            state_q <= fesm_pkg::FESM_ERASING;
        end
        fesm_pkg::FESM_SUSPWAIT: begin
          if (susp_done)
            state_q <= fesm_pkg::FESM_SUSP;
        end
        fesm_pkg::FESM_SUSP: begin
          if (is_resume)
            state_q <= fesm_pkg::FESM_ERASING;
          else if (is_reset)
            state_q <= fesm_pkg::FESM_READ;
          // Any other write falls through untouched
        end
        default: state_q <= fesm_pkg::FESM_READ;
      endcase
    end
  end

  // Recovery timer run, started by system reset or a reset-flash outside the read state
  always_ff @(posedge clk_in) begin
    if (!resetn_in)
      in_reset_q <= 1'b0;
    else
      in_reset_q <= rec_busy && !rec_done;
  end

  // Sectors under erase, locked ones dropped
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      erase_sectors_q <= '0;
    end else if (erase_start_in && !busy_other_in &&
                 (state_q == fesm_pkg::FESM_READ || state_q == fesm_pkg::FESM_TIMEOUT)) begin
      erase_sectors_q <= erase_sectors_q | (sel_vec &
                         ~{boot_lock_in[3:0], main_lock_in});
    end else if (state_q == fesm_pkg::FESM_READ) begin
      erase_sectors_q <= '0;
    end
  end

  // Unlock prefix tracker; reset-flash works with or without it
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      unlock_q <= 2'b00;
    end else if (flash_wr) begin
      if (bus_addr_in == fesm_pkg::UNLOCK_ADDR1 && bus_wdata_in == fesm_pkg::UNLOCK_VAL1)
        unlock_q <= 2'b01;
      else if (unlock_q == 2'b01 && bus_addr_in == fesm_pkg::UNLOCK_ADDR2 &&
               bus_wdata_in == fesm_pkg::UNLOCK_VAL2)
        unlock_q <= 2'b10;
      else
        unlock_q <= 2'b00;
    end
  end

  // Toggle flag flips on each status read of the erased sector while busy
  always_ff @(posedge clk_in) begin
    if (!resetn_in)
      toggle_q <= 1'b0;
    else if (bus_rd_in && hits_erase && (state_q == fesm_pkg::FESM_TIMEOUT ||
             state_q == fesm_pkg::FESM_ERASING || state_q == fesm_pkg::FESM_SUSPWAIT))
      toggle_q <= ~toggle_q;
  end

  // ---------------------------------------------------------------------------
  // Space map register and reads
  // ---------------------------------------------------------------------------
  // Boot value loaded once after reset, then software may rewrite it
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      space_map_q  <= fesm_pkg::RESET_VAL_ZERO;
      map_loaded_q <= 1'b0;
    end else if (!map_loaded_q) begin
      space_map_q  <= space_map_boot_in & fesm_pkg::MAP_USED_MASK;
      map_loaded_q <= 1'b1;
    end else if (reg_wr && bus_addr_in[7:0] == fesm_pkg::OFS_SPACE_MAP) begin
      space_map_q  <= bus_wdata_in & fesm_pkg::MAP_USED_MASK;
    end
  end

  // Lock registers have no write path here
  always_comb begin
    case (bus_addr_in[7:0])
      fesm_pkg::OFS_MAIN_LOCK: reg_rdata = main_lock_in;
      fesm_pkg::OFS_BOOT_LOCK: reg_rdata = (boot_lock_in & fesm_pkg::BOOT_LOCK_MASK) |
                                           {secured_in, 7'h00};
      fesm_pkg::OFS_SPACE_MAP: reg_rdata = space_map_q;
      default:                 reg_rdata = 8'h00;
    endcase
  end

  // Status byte for reads inside the erased sector
  always_comb begin
    status = 8'h00;
    status[fesm_pkg::ST_TOGGLE_BIT] = toggle_q;
    status[fesm_pkg::ST_ERROR_BIT]  = error_in;
    status[fesm_pkg::ST_TIMER_BIT]  = (state_q != fesm_pkg::FESM_TIMEOUT);
  end

  // Registered read data
  always_ff @(posedge clk_in) begin
    if (!resetn_in)
      rdata_q <= 8'h00;
    else if (reg_rd)
      rdata_q <= reg_rdata;
    else if (bus_rd_in && hits_erase && state_q != fesm_pkg::FESM_READ &&
             state_q != fesm_pkg::FESM_SUSP)
      rdata_q <= status;
    else if (bus_rd_in)
      rdata_q <= 8'h00;
  end

  assign bus_rdata_out            = rdata_q;
  assign peripheral_io_enable_out = space_map_q[fesm_pkg::MAP_PIO_BIT];
  assign read_invalid_out         = (bus_rd_in || bus_fetch_in) && hits_erase &&
                                    (state_q == fesm_pkg::FESM_SUSP);
  assign erase_active_out         = (state_q == fesm_pkg::FESM_TIMEOUT) ||
                                    (state_q == fesm_pkg::FESM_ERASING);
  assign erase_suspended_out      = (state_q == fesm_pkg::FESM_SUSP);
  assign program_refused_out      = flash_wr && ((state_q == fesm_pkg::FESM_SUSP && !is_resume && !is_reset) ||
                                    (|(sel_vec & {boot_lock_in[3:0], main_lock_in})));

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_suspend_enters;
    @(posedge clk_in) disable iff (!resetn_in)
    (is_suspend && state_q == fesm_pkg::FESM_ERASING) |=> state_q == fesm_pkg::FESM_SUSPWAIT;
  endproperty
  a_suspend_enters: assert property (p_suspend_enters) else $error("suspend not taken");

  property p_suspend_idle;
    @(posedge clk_in) disable iff (!resetn_in)
    (is_suspend && state_q == fesm_pkg::FESM_READ) |=> state_q == fesm_pkg::FESM_READ;
  endproperty
  a_suspend_idle: assert property (p_suspend_idle) else $error("suspend acted in read");

  property p_suspend_window;
    @(posedge clk_in) disable iff (!resetn_in)
    $rose(state_q == fesm_pkg::FESM_SUSPWAIT) |-> ##24 state_q == fesm_pkg::FESM_SUSPWAIT
      ##[1:1000] state_q == fesm_pkg::FESM_SUSP;
  endproperty
  a_suspend_window: assert property (p_suspend_window) else $error("suspend delay out of range");

  property p_resume;
    @(posedge clk_in) disable iff (!resetn_in)
    (state_q == fesm_pkg::FESM_SUSP && is_resume) |=> state_q == fesm_pkg::FESM_ERASING;
  endproperty
  a_resume: assert property (p_resume) else $error("resume not taken");

  property p_reset_susp;
    @(posedge clk_in) disable iff (!resetn_in)
    (state_q == fesm_pkg::FESM_SUSP && is_reset) |=> state_q == fesm_pkg::FESM_READ;
  endproperty
  a_reset_susp: assert property (p_reset_susp) else $error("reset did not abandon erase");

  property p_discard;
    @(posedge clk_in) disable iff (!resetn_in)
    (state_q == fesm_pkg::FESM_SUSP && flash_wr && !is_resume && !is_reset)
      |=> state_q == fesm_pkg::FESM_SUSP && $stable(erase_sectors_q);
  endproperty
  a_discard: assert property (p_discard) else $error("write changed suspended state");

  property p_invalid;
    @(posedge clk_in) disable iff (!resetn_in)
    (bus_rd_in && state_q == fesm_pkg::FESM_SUSP && !hits_erase) |-> !read_invalid_out;
  endproperty
  a_invalid: assert property (p_invalid) else $error("other sector read flagged");

  property p_timer_flag;
    @(posedge clk_in) disable iff (!resetn_in)
    (reg_rd == 1'b0 && bus_rd_in && hits_erase && state_q == fesm_pkg::FESM_TIMEOUT)
      |=> !bus_rdata_out[fesm_pkg::ST_TIMER_BIT];
  endproperty
  a_timer_flag: assert property (p_timer_flag) else $error("timer flag not zero in window");

  property p_map_write;
    @(posedge clk_in) disable iff (!resetn_in)
    (map_loaded_q && reg_wr && bus_addr_in[7:0] == fesm_pkg::OFS_SPACE_MAP)
      |=> space_map_q == ($past(bus_wdata_in) & fesm_pkg::MAP_USED_MASK);
  endproperty
  a_map_write: assert property (p_map_write) else $error("space map not written");

endmodule : fesm_core

// *** fesm_counter.sv ***
// Down counter: load a value, count to zero, pulse done
module fesm_counter #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  // Control
  input  wire logic         load_in,
  input  wire logic [W-1:0] value_in,
  input  wire logic         stop_in,
  // Status
  output logic              busy_out,
  output logic              done_out
);

  logic [W-1:0] cnt_q;
  logic         busy_q;

  // Count down while busy, done on reaching one
  always_ff @(posedge clk_in) begin
    if (!resetn_in || stop_in) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (load_in) begin
      cnt_q  <= value_in;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      cnt_q  <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      busy_q <= (cnt_q > {{(W-1){1'b0}}, 1'b1});
    end
  end

  assign busy_out = busy_q;
  assign done_out = busy_q && (cnt_q == {{(W-1){1'b0}}, 1'b1}) && !load_in && !stop_in;

endmodule : fesm_counter

// *** fesm_host.sv ***
// MCU core bus model: one strobe per cycle, selects from the decoder
module fesm_host (
  // Clock and answers
  input  wire logic        clk_in,
  input  wire logic [7:0]  rdata_in,
  input  wire logic [4:0]  flags_in,
  // Strobes: wr, rd, fetch, erase code
  output logic [3:0]       strobe_out,
  output logic [11:0]      addr_out,
  output logic [7:0]       wdata_out,
  // Decoded selects
  output logic [7:0]       msel_out,
  output logic [3:0]       bsel_out,
  output logic [1:0]       ssel_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus at time zero
  initial begin
    {strobe_out, addr_out, wdata_out, msel_out, bsel_out, ssel_out} = '0;
  end

  // One access; flags read mid-cycle, data after the sampling edge
  task automatic cyc(input logic [3:0] k, input logic [11:0] a, input logic [7:0] d,
                     input logic [7:0] m, input logic [3:0] b, input logic [1:0] s,
                     output logic [7:0] q, output logic [4:0] f);
    @(posedge clk_in) #1;
    {strobe_out, addr_out, wdata_out} = {k, a, d};
    {msel_out, bsel_out, ssel_out} = {m, b, s};
    #1 f = flags_in;
    @(posedge clk_in) #1;
    strobe_out = 4'h0;
    wdata_out = ~d; // Released data never echoes the last byte
    {msel_out, bsel_out, ssel_out} = '0;
    q = rdata_in;
  endtask : cyc
endmodule : fesm_host

// *** fesm_pkg.sv ***
package fesm_pkg;

  // ---------------------------------------------------------------------------
  // Command codes and unlock cycle values
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  CMD_SUSPEND      = 8'hb0;
  localparam logic [7:0]  CMD_RESUME       = 8'h30;
  localparam logic [7:0]  CMD_RESET_FLASH  = 8'hf0;
  localparam logic [7:0]  UNLOCK_VAL1      = 8'haa;
  localparam logic [7:0]  UNLOCK_VAL2      = 8'h55;
  localparam logic [11:0] UNLOCK_ADDR1     = 12'h555;
  localparam logic [11:0] UNLOCK_ADDR2     = 12'haaa;

  // ---------------------------------------------------------------------------
  // Control register space offsets (relative to control_register_space)
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  OFS_MAIN_LOCK    = 8'hc0;
  localparam logic [7:0]  OFS_BOOT_LOCK    = 8'hc2;
  localparam logic [7:0]  OFS_SPACE_MAP    = 8'he2;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int          MAP_PIO_BIT      = 7;
  localparam int          MAP_RD_MAIN_BIT  = 4;
  localparam int          MAP_RD_BOOT_BIT  = 3;
  localparam int          MAP_PF_MAIN_BIT  = 2;
  localparam int          MAP_PF_BOOT_BIT  = 1;
  localparam int          MAP_PF_SRAM_BIT  = 0;
  localparam logic [7:0]  MAP_USED_MASK    = 8'h9f;
  localparam int          SECURED_BIT      = 7;
  localparam logic [7:0]  BOOT_LOCK_MASK   = 8'h0f;

  // Status bit positions in a status read
  localparam int          ST_ERROR_BIT     = 5;
  localparam int          ST_TOGGLE_BIT    = 6;
  localparam int          ST_TIMER_BIT     = 3;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int          CLK_MHZ          = 250;
  localparam int          SUSP_MIN_NS      = 100;
  localparam int          SUSP_MAX_NS      = 15000;
  localparam int          RECOVER_NS       = 25000;
  localparam int          SUSP_MIN_CYC     = (SUSP_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int          SUSP_MAX_CYC     = (SUSP_MAX_NS * CLK_MHZ) / 1000;
  localparam int          RECOVER_CYC      = (RECOVER_NS * CLK_MHZ) / 1000;
  localparam int          SUSP_DELAY_CYC   = SUSP_MIN_CYC + 4;
  localparam int          ABORT_DELAY_CYC  = 64;
  localparam logic [7:0]  RESET_VAL_ZERO   = 8'h00;

  // Flash engine state
  typedef enum logic [4:0] {
    FESM_READ     = 5'b00001,
    FESM_TIMEOUT  = 5'b00010,
    FESM_ERASING  = 5'b00100,
    FESM_SUSPWAIT = 5'b01000,
    FESM_SUSP     = 5'b10000
  } fesm_state_e;

endpackage : fesm_pkg

// *** test_fesm_core.sv ***
module test_fesm_core;
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------------------
  logic        clk_in, resetn_in, pio, erase_active_out, erase_suspended_out;
  logic [3:0]  stb, bsel;
  logic [11:0] addr;
  logic [7:0]  wdata, msel, rdata, q, mlock, block, mapb;
  logic [1:0]  ssel;
  wire  [4:0]  fl;
  logic [4:0]  f;
  logic        sec;
  int          n_mismatch, n_tests, n;

  fesm_host i_fesm_host (.clk_in, .rdata_in(rdata), .flags_in(fl), .strobe_out(stb), .addr_out(addr),
                         .wdata_out(wdata), .msel_out(msel), .bsel_out(bsel), .ssel_out(ssel));

  fesm_core i_fesm_core (.clk_in, .resetn_in, .bus_wr_in(stb[0]), .bus_rd_in(stb[1]),
    .bus_fetch_in(stb[2]), .bus_addr_in(addr), .bus_wdata_in(wdata),
    .main_sector_selects_in(msel), .boot_sector_selects_in(bsel), .static_memory_select_in(ssel[0]),
    .control_register_space_in(ssel[1]), .peripheral_space_in(1'b0), .main_lock_in(mlock),
    .boot_lock_in(block), .secured_in(sec), .space_map_boot_in(mapb), .erase_start_in(stb[3]),
    .busy_other_in(1'b0), .error_in(1'b0), .bus_rdata_out(rdata), .main_flash_en_out(fl[0]),
    .boot_flash_en_out(fl[1]), .sram_en_out(fl[2]), .regs_en_out(), .periph_en_out(),
    .peripheral_io_enable_out(pio), .read_invalid_out(fl[4]), .erase_active_out,
    .erase_suspended_out, .program_refused_out(fl[3]));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic acc(input logic [3:0] k, input logic [11:0] a, input logic [7:0] d,
                     input logic [7:0] m, input logic [3:0] b, input logic [1:0] s);
    i_fesm_host.cyc(k, a, d, m, b, s, q, f);
  endtask : acc

  // Bounded wait on the erase state; a run-out ends the run
  task automatic wait_on(input bit act, input logic v, input int lim);
    for (n = 0; n < lim; n++) begin
      @(posedge clk_in) #1;
      if ((act ? erase_active_out : erase_suspended_out) === v) return;
    end
    n_mismatch++;
    end_of_test();
  endtask : wait_on

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_regs();
    acc(4'h2, {4'h0, fesm_pkg::OFS_MAIN_LOCK}, 8'h00, 8'h00, 4'h0, 2'h2);
    chk("main_lock", 8'h5a, q);
    acc(4'h1, {4'h0, fesm_pkg::OFS_MAIN_LOCK}, 8'h00, 8'h00, 4'h0, 2'h2);
    acc(4'h2, {4'h0, fesm_pkg::OFS_MAIN_LOCK}, 8'h00, 8'h00, 4'h0, 2'h2);
    chk("main_lock_ro", 8'h5a, q);
    acc(4'h2, {4'h0, fesm_pkg::OFS_BOOT_LOCK}, 8'h00, 8'h00, 4'h0, 2'h2);
    chk("boot_lock", 8'h86, q);
    acc(4'h1, 12'h000, fesm_pkg::CMD_RESET_FLASH, 8'h01, 4'h0, 2'h0);
    acc(4'h2, {4'h0, fesm_pkg::OFS_SPACE_MAP}, 8'h00, 8'h00, 4'h0, 2'h2);
    chk("map_boot", 8'h9f, q);
    chk("pio_on", 8'h01, {7'h0, pio});
    acc(4'h1, {4'h0, fesm_pkg::OFS_SPACE_MAP}, 8'h1f, 8'h00, 4'h0, 2'h2);
    acc(4'h2, {4'h0, fesm_pkg::OFS_SPACE_MAP}, 8'h00, 8'h00, 4'h0, 2'h2);
    chk("map_wr", 8'h1f, q);
    chk("pio_off", 8'h00, {7'h0, pio});
    $display("t_regs done");
  endtask : t_regs

  // Overlapping selects on program fetch; flags {inv, refused, sram, boot, main}
  task automatic t_prio();
    acc(4'h4, 12'h000, 8'h00, 8'h01, 4'h1, 2'h1);
    chk("sram_wins", 8'h04, {3'h0, f});
    acc(4'h4, 12'h000, 8'h00, 8'h01, 4'h1, 2'h0);
    chk("boot_wins", 8'h02, {3'h0, f});
    acc(4'h4, 12'h000, 8'h00, 8'h00, 4'h0, 2'h0);
    chk("no_select", 8'h00, {3'h0, f});
    acc(4'h1, {4'h0, fesm_pkg::OFS_SPACE_MAP}, 8'h18, 8'h00, 4'h0, 2'h2);
    acc(4'h4, 12'h000, 8'h00, 8'h01, 4'h0, 2'h0);
    chk("fetch_off", 8'h00, {3'h0, f});
    acc(4'h2, 12'h000, 8'h00, 8'h01, 4'h0, 2'h0);
    chk("read_main", 8'h01, {3'h0, f});
    $display("t_prio done");
  endtask : t_prio

  task automatic t_suspend();
    logic prev;
    acc(4'h1, 12'h000, fesm_pkg::CMD_SUSPEND, 8'h01, 4'h0, 2'h0);
    repeat (fesm_pkg::SUSP_DELAY_CYC + 4) @(posedge clk_in);
    chk("susp_idle", 8'h00, {7'h0, erase_suspended_out});
    acc(4'h8, 12'h000, 8'h00, 8'h02, 4'h0, 2'h0);
    repeat (4) @(posedge clk_in);
    chk("locked_sector", 8'h00, {7'h0, erase_active_out});
    acc(4'h8, 12'h000, 8'h00, 8'h01, 4'h0, 2'h0);
    acc(4'h1, 12'h000, fesm_pkg::CMD_SUSPEND, 8'h01, 4'h0, 2'h0);
    wait_on(0, 1'b1, fesm_pkg::SUSP_MAX_CYC);
    chk("susp_min", 8'h01, 8'(n + 1 >= fesm_pkg::SUSP_MIN_CYC));
    acc(4'h2, 12'h000, 8'h00, 8'h01, 4'h0, 2'h0);
    chk("own_invalid", 8'h10, {3'h0, f} & 8'h10);
    acc(4'h2, 12'h000, 8'h00, 8'h02, 4'h0, 2'h0);
    chk("other_valid", 8'h00, {3'h0, f} & 8'h10);
    acc(4'h1, 12'h000, 8'h12, 8'h01, 4'h0, 2'h0);
    chk("prog_refused", 8'h08, {3'h0, f} & 8'h08);
    chk("still_susp", 8'h01, {7'h0, erase_suspended_out});
    acc(4'h1, 12'h000, fesm_pkg::CMD_RESUME, 8'h01, 4'h0, 2'h0);
    chk("resumed", 8'h02, {6'h0, erase_active_out, erase_suspended_out});
    acc(4'h2, 12'h000, 8'h00, 8'h01, 4'h0, 2'h0);
    chk("timer_flag", 8'h08, q & 8'h08);
    prev = q[fesm_pkg::ST_TOGGLE_BIT];
    acc(4'h2, 12'h000, 8'h00, 8'h01, 4'h0, 2'h0);
    chk("toggle", {7'h0, ~prev}, {7'h0, q[fesm_pkg::ST_TOGGLE_BIT]});
    acc(4'h1, fesm_pkg::UNLOCK_ADDR1, fesm_pkg::UNLOCK_VAL1, 8'h01, 4'h0, 2'h0);
    acc(4'h1, fesm_pkg::UNLOCK_ADDR2, fesm_pkg::UNLOCK_VAL2, 8'h01, 4'h0, 2'h0);
    acc(4'h1, 12'h000, fesm_pkg::CMD_RESET_FLASH, 8'h01, 4'h0, 2'h0);
    wait_on(1, 1'b0, fesm_pkg::RECOVER_CYC);
    acc(4'h8, 12'h000, 8'h00, 8'h01, 4'h0, 2'h0);
    acc(4'h2, 12'h000, 8'h00, 8'h01, 4'h0, 2'h0);
    chk("timer_zero", 8'h00, q & 8'h08);
    acc(4'h1, 12'h000, fesm_pkg::CMD_SUSPEND, 8'h01, 4'h0, 2'h0);
    wait_on(0, 1'b1, fesm_pkg::SUSP_MAX_CYC);
    acc(4'h1, 12'h000, fesm_pkg::CMD_RESET_FLASH, 8'h01, 4'h0, 2'h0);
    wait_on(1, 1'b0, fesm_pkg::RECOVER_CYC);
    chk("abandoned", 8'h00, {7'h0, erase_suspended_out});
    $display("t_suspend done");
  endtask : t_suspend

  // System reset in mid-erase, held for the recovery time
  task automatic t_sysreset();
    acc(4'h8, 12'h000, 8'h00, 8'h01, 4'h0, 2'h0);
    chk("erase_on", 8'h01, {7'h0, erase_active_out});
    resetn_in = 1'b0;
    repeat (fesm_pkg::RECOVER_CYC) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #1 chk("reset_abort", 8'h00, {7'h0, erase_active_out});
    acc(4'h2, {4'h0, fesm_pkg::OFS_SPACE_MAP}, 8'h00, 8'h00, 4'h0, 2'h2);
    chk("map_reload", 8'h9f, q);
    $display("t_sysreset done");
  endtask : t_sysreset

  // ---------------------------------------------------------------------------
  // Clock, reset and main sequence
  // ---------------------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  initial begin
    {n_mismatch, n_tests} = '0;
    {mlock, block, sec, mapb} = {8'h5a, 8'h36, 1'b1, 8'hff};
    resetn_in = 1'b0;
    repeat (4) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    repeat (3) @(posedge clk_in);
    t_regs();
    t_prio();
    t_suspend();
    t_sysreset();
    end_of_test();
  end
endmodule : test_fesm_core
